// ---- hdl/hcf_frame_top.sv ----
// Device end of the host message exchange: checks commands, frames replies
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// (RULE_01) Every frame starts with marker 0x23
// (RULE_02) One header layout for all traffic
// (RULE_03) Policy byte: bit0 always, bit1 errors
// (RULE_04) Bytes 2-3 hold total frame length
// (RULE_05) Byte 4 destination node: controller 1, host 0
// (RULE_06) Byte 5 destination interface
// (RULE_07) Bytes 6-7 origin node and interface
// (RULE_08) Replies swap destination and origin fields
// (RULE_09) Host sends commands with type 0
// (RULE_10) Type 1 response, type 2 acknowledgment
// (RULE_11) Host tag echoed unchanged
// (RULE_12) Byte 11 holds the command code
// (RULE_13) Whole frame at most 1024 bytes
// (RULE_14) Header 12 bytes, parameters at most 1012
// (RULE_15) Header-only commands are accepted
// (RULE_16) No response for commands defining none
// (RULE_17) Host uses node 0, any port
// (RULE_18) Host should request acknowledgments
// (RULE_19) Multi-byte fields low byte first
// (RULE_20) Host zeroes reserved bytes and bits
// (RULE_21) Ack payload: fault code, zero-terminated text
// (RULE_22) Errors-only policy yields exactly one frame
// (RULE_23) Bad marker or length means malformed
module hcf_frame_top (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_valid,
    input wire hcf_pkg::hcf_byte_t rx_in,
    output logic rx_ready,
    output logic param_valid,
    output hcf_pkg::hcf_byte_t param_out,
    output logic tx_valid,
    output hcf_pkg::hcf_byte_t tx_out,
    input wire logic tx_ready
);
    logic [1:0] rst_pipe;
    logic rst_n;
    hcf_pkg::hcf_hdr_t cmd;
    hcf_pkg::hcf_hdr_t rsp;
    hcf_pkg::hcf_tx_state_t state_reg;
    logic hdr_valid;
    logic hdr_bad;
    logic resume_reg;
    logic req;
    logic wr;
    logic start_w;
    logic start_ok;
    logic send_resp;
    logic send_ack;
    logic pend_reg;
    logic bad_reg;
    logic fail_reg;
    logic has_resp_reg;
    logic ack_pend_reg;
    logic kind_ack_reg;
    logic [31:0] fault_reg;
    logic [10:0] resp_len_reg;
    logic [9:0] wr_ptr_reg;
    logic [10:0] idx_reg;
    logic [10:0] resp_pay;
    logic [10:0] text_n;
    logic [10:0] frame_len;
    logic [31:0] fault_w;
    logic [9:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] byte_w;
    logic buf_we;

    // Reset release through two stages
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    hcf_rx_parse u_rx (
        .clock(clock),
        .rst_n(rst_n),
        .rx_valid(rx_valid),
        .rx_in(rx_in),
        .resume(resume_reg),
        .rx_ready(rx_ready),
        .param_out(param_out),
        .param_valid(param_valid),
        .hdr_valid(hdr_valid),
        .hdr_bad(hdr_bad),
        .hdr(cmd)
    );

    hcf_buf u_buf (
        .clock(clock),
        .wr_en(buf_we),
        .wr_addr(wr_ptr_reg),
        .wr_data(wb_dat_i[7:0]),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Bus decode: one wait state, every address answers
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign start_w = wr && wb_adr_i == hcf_pkg::REG_CTRL && wb_sel_i[0]
        && wb_dat_i[hcf_pkg::CTRL_START];
    assign start_ok = start_w && pend_reg && state_reg == hcf_pkg::TX_IDLE;
    assign buf_we = wr && wb_adr_i == hcf_pkg::REG_TX_DATA && wb_sel_i[0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0;
        end else if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                hcf_pkg::REG_CTRL: wb_dat_o <= {29'h0, has_resp_reg, fail_reg, 1'b0};
                hcf_pkg::REG_STATUS: wb_dat_o <= {6'h0, wr_ptr_reg, 13'h0,
                    bad_reg, state_reg != hcf_pkg::TX_IDLE, pend_reg};
                hcf_pkg::REG_HDR0: wb_dat_o <= cmd[31:0];
                hcf_pkg::REG_HDR1: wb_dat_o <= cmd[63:32];
                hcf_pkg::REG_HDR2: wb_dat_o <= cmd[95:64];
                hcf_pkg::REG_FAULT: wb_dat_o <= fault_reg;
                hcf_pkg::REG_RESP_LEN: wb_dat_o <= {21'h0, resp_len_reg};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    // Outcome bits are taken with the start command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fail_reg <= 1'b0;
            has_resp_reg <= 1'b0;
        end else if (start_ok) begin
            fail_reg <= wb_dat_i[hcf_pkg::CTRL_FAIL];
            has_resp_reg <= wb_dat_i[hcf_pkg::CTRL_HAS_RESP];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_fault
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    fault_reg[gi*8 +: 8] <= 8'h00;
                end else if (wr && wb_adr_i == hcf_pkg::REG_FAULT && wb_sel_i[gi]) begin
                    fault_reg[gi*8 +: 8] <= wb_dat_i[gi*8 +: 8];
                end
            end
        end
    endgenerate

    // Writing the length rewinds the payload pointer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resp_len_reg <= 11'h000;
            wr_ptr_reg <= 10'h000;
        end else if (wr && wb_adr_i == hcf_pkg::REG_RESP_LEN) begin
            resp_len_reg <= wb_dat_i[10:0];
            wr_ptr_reg <= 10'h000;
        end else if (buf_we) begin
            wr_ptr_reg <= wr_ptr_reg + 10'h001;
        end
    end

    // Hardware set wins over the clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else begin
            if (hdr_valid) begin
                pend_reg <= 1'b1;
            end else if (start_ok) begin
                pend_reg <= 1'b0;
            end
            if (hdr_bad) begin
                bad_reg <= 1'b1; // [RULE_23]
            end else if (wr && wb_adr_i == hcf_pkg::REG_STATUS && wb_sel_i[0]
                && wb_dat_i[hcf_pkg::ST_BAD]) begin
                bad_reg <= 1'b0;
            end
        end
    end

    // Which frames a finished command produces
    assign send_resp = !wb_dat_i[hcf_pkg::CTRL_FAIL]
        && wb_dat_i[hcf_pkg::CTRL_HAS_RESP]; // [RULE_16]
    assign send_ack = wb_dat_i[hcf_pkg::CTRL_FAIL]
        ? (cmd.ack_policy[hcf_pkg::POL_ALWAYS] || cmd.ack_policy[hcf_pkg::POL_ERRORS])
        : cmd.ack_policy[hcf_pkg::POL_ALWAYS]; // [RULE_03] [RULE_22]

    // Lengths are clamped so no frame passes the message limit
    assign resp_pay = resp_len_reg > hcf_pkg::PAY_MAX ? hcf_pkg::PAY_MAX : resp_len_reg;
    always_comb begin
        text_n = 11'h001;
        if (fail_reg && resp_len_reg > hcf_pkg::TEXT_MAX) begin
            text_n = hcf_pkg::TEXT_MAX;
        end else if (fail_reg && resp_len_reg != 11'h000) begin
            text_n = resp_len_reg;
        end
    end
    assign frame_len = kind_ack_reg ? hcf_pkg::HDR_LEN + hcf_pkg::FAULT_LEN + text_n
        : hcf_pkg::HDR_LEN + resp_pay; // [RULE_13] [RULE_14]

    // Reply header built from the held command
    always_comb begin
        rsp.frame_marker = hcf_pkg::MARKER; // [RULE_01] [RULE_02]
        rsp.ack_policy = cmd.ack_policy;
        rsp.length = {5'h00, frame_len}; // [RULE_04]
        rsp.dest_node_id = cmd.origin_node_id; // [RULE_08] [RULE_05]
        rsp.dest_interface = cmd.origin_interface; // [RULE_06]
        rsp.origin_node_id = cmd.dest_node_id; // [RULE_07]
        rsp.origin_interface = cmd.dest_interface;
        rsp.frame_type = kind_ack_reg ? hcf_pkg::FT_ACK : hcf_pkg::FT_RESP; // [RULE_10]
        rsp.host_tag = cmd.host_tag; // [RULE_11]
        rsp.rsvd = 8'h00;
        rsp.cmd_code = cmd.cmd_code; // [RULE_12]
    end

    assign fault_w = fail_reg ? fault_reg : 32'h0; // [RULE_21]
    assign rd_addr = kind_ack_reg ? 10'(idx_reg - hcf_pkg::HDR_LEN - hcf_pkg::FAULT_LEN)
        : 10'(idx_reg - hcf_pkg::HDR_LEN);

    // Byte at the current index, low byte first for wide fields
    always_comb begin
        byte_w = rd_data;
        if (idx_reg < hcf_pkg::HDR_LEN) begin
            byte_w = rsp[{idx_reg[3:0], 3'h0} +: 8]; // [RULE_19]
        end else if (kind_ack_reg && idx_reg < hcf_pkg::HDR_LEN + hcf_pkg::FAULT_LEN) begin
            byte_w = fault_w[{idx_reg[1:0], 3'h0} +: 8]; // [RULE_21]
        end else if (kind_ack_reg && (!fail_reg || idx_reg == frame_len - 11'h001)) begin
            byte_w = 8'h00; // [RULE_21]
        end
    end

    // Three cycles per byte: the memory read needs a cycle of its own
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= hcf_pkg::TX_IDLE;
            idx_reg <= 11'h000;
            kind_ack_reg <= 1'b0;
            ack_pend_reg <= 1'b0;
            resume_reg <= 1'b0;
        end else begin
            resume_reg <= 1'b0;
            unique case (state_reg)
                hcf_pkg::TX_IDLE: begin
                    idx_reg <= 11'h000;
                    if (start_ok) begin
                        kind_ack_reg <= !send_resp;
                        ack_pend_reg <= send_resp && send_ack; // [RULE_22]
                        if (send_resp || send_ack) begin
                            state_reg <= hcf_pkg::TX_FETCH;
                        end else begin
                            resume_reg <= 1'b1;
                        end
                    end
                end
                hcf_pkg::TX_FETCH: state_reg <= hcf_pkg::TX_LOAD;
                hcf_pkg::TX_LOAD: state_reg <= hcf_pkg::TX_SEND;
                hcf_pkg::TX_SEND: begin
                    if (tx_ready && idx_reg != frame_len - 11'h001) begin
                        idx_reg <= idx_reg + 11'h001;
                        state_reg <= hcf_pkg::TX_FETCH;
                    end else if (tx_ready && ack_pend_reg) begin
                        idx_reg <= 11'h000;
                        kind_ack_reg <= 1'b1;
                        ack_pend_reg <= 1'b0;
                        state_reg <= hcf_pkg::TX_FETCH;
                    end else if (tx_ready) begin
                        state_reg <= hcf_pkg::TX_IDLE;
                        resume_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_out <= '0;
        end else if (state_reg == hcf_pkg::TX_LOAD) begin
            tx_valid <= 1'b1;
            tx_out <= '{last: idx_reg == frame_len - 11'h001, data: byte_w};
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    property p_marker;
        @(posedge clock) disable iff (!rst_n)
        tx_valid && idx_reg == 11'h000 |-> tx_out.data == 8'h23;
    endproperty
    a_marker: assert property (p_marker) else $error("marker byte wrong"); // [RULE_01]

    property p_type;
        @(posedge clock) disable iff (!rst_n)
        tx_valid && idx_reg == hcf_pkg::IDX_TYPE
        |-> tx_out.data == (kind_ack_reg ? 8'h02 : 8'h01);
    endproperty
    a_type: assert property (p_type) else $error("frame type wrong"); // [RULE_10]

    property p_tag;
        @(posedge clock) disable iff (!rst_n)
        tx_valid && idx_reg == hcf_pkg::IDX_TAG |-> tx_out.data == cmd.host_tag;
    endproperty
    a_tag: assert property (p_tag) else $error("host tag altered"); // [RULE_11]

    property p_swap;
        @(posedge clock) disable iff (!rst_n)
        tx_valid && idx_reg == hcf_pkg::IDX_DEST |-> tx_out.data == cmd.origin_node_id;
    endproperty
    a_swap: assert property (p_swap) else $error("addresses not swapped"); // [RULE_08]

    property p_len_lsb;
        @(posedge clock) disable iff (!rst_n)
        tx_valid && idx_reg == hcf_pkg::IDX_LEN_LO |-> tx_out.data == frame_len[7:0];
    endproperty
    a_len_lsb: assert property (p_len_lsb) else $error("length not low first"); // [RULE_19]

    property p_len_max;
        @(posedge clock) disable iff (!rst_n)
        tx_valid && tx_out.last |-> idx_reg < 11'h400 && idx_reg >= 11'h00B;
    endproperty
    a_len_max: assert property (p_len_max) else $error("frame size out of bounds"); // [RULE_13]

    property p_fail_no_resp;
        @(posedge clock) disable iff (!rst_n)
        state_reg != hcf_pkg::TX_IDLE && fail_reg |-> kind_ack_reg && !ack_pend_reg;
    endproperty
    a_fail_no_resp: assert property (p_fail_no_resp) else $error("response on failure"); // [RULE_22]

    property p_no_def;
        @(posedge clock) disable iff (!rst_n)
        start_ok && !wb_dat_i[hcf_pkg::CTRL_HAS_RESP] |=> kind_ack_reg || state_reg == hcf_pkg::TX_IDLE;
    endproperty
    a_no_def: assert property (p_no_def) else $error("undefined response sent"); // [RULE_16]

    property p_ok_code;
        @(posedge clock) disable iff (!rst_n)
        tx_valid && kind_ack_reg && !fail_reg && idx_reg >= hcf_pkg::HDR_LEN |-> tx_out.data == 8'h00;
    endproperty
    a_ok_code: assert property (p_ok_code) else $error("success ack not zero"); // [RULE_21]

    property p_quiet;
        @(posedge clock) disable iff (!rst_n)
        start_ok && cmd.ack_policy[1:0] == 2'h0 && wb_dat_i[hcf_pkg::CTRL_FAIL]
        |=> state_reg == hcf_pkg::TX_IDLE ##1 rx_ready;
    endproperty
    a_quiet: assert property (p_quiet) else $error("frame sent without policy"); // [RULE_03]
endmodule : hcf_frame_top

// ---- inc/hcf_pkg.sv ----
// Shared constants and types for the host command frame header block
package hcf_pkg;
    localparam logic [7:0] MARKER = 8'h23;
    localparam logic [10:0] HDR_LEN = 11'h00C;
    localparam logic [10:0] MSG_MAX = 11'h400;
    localparam logic [10:0] PAY_MAX = 11'h3F4;
    localparam logic [10:0] FAULT_LEN = 11'h004;
    localparam logic [10:0] TEXT_MAX = PAY_MAX - FAULT_LEN;
    localparam logic [7:0] FT_CMD = 8'h00;
    localparam logic [7:0] FT_RESP = 8'h01;
    localparam logic [7:0] FT_ACK = 8'h02;
    localparam int POL_ALWAYS = 0;
    localparam int POL_ERRORS = 1;
    localparam logic [7:0] NODE_HOST = 8'h00;
    localparam logic [7:0] NODE_CTRL = 8'h01;
    localparam logic [10:0] IDX_LEN_LO = 11'h002;
    localparam logic [10:0] IDX_DEST = 11'h004;
    localparam logic [10:0] IDX_TYPE = 11'h008;
    localparam logic [10:0] IDX_TAG = 11'h009;
    // Register byte offsets on the bus
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_HDR0 = 8'h08;
    localparam logic [7:0] REG_HDR1 = 8'h0C;
    localparam logic [7:0] REG_HDR2 = 8'h10;
    localparam logic [7:0] REG_FAULT = 8'h14;
    localparam logic [7:0] REG_RESP_LEN = 8'h18;
    localparam logic [7:0] REG_TX_DATA = 8'h1C;
    localparam int CTRL_START = 0;
    localparam int CTRL_FAIL = 1;
    localparam int CTRL_HAS_RESP = 2;
    localparam int ST_PEND = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_BAD = 2;
    // Byte i of the header sits at bits [8i+7:8i]
    typedef struct packed {
        logic [7:0] cmd_code;
        logic [7:0] rsvd;
        logic [7:0] host_tag;
        logic [7:0] frame_type;
        logic [7:0] origin_interface;
        logic [7:0] origin_node_id;
        logic [7:0] dest_interface;
        logic [7:0] dest_node_id;
        logic [15:0] length;
        logic [7:0] ack_policy;
        logic [7:0] frame_marker;
    } hcf_hdr_t;
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } hcf_byte_t;
    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_FETCH = 2'h1,
        TX_LOAD = 2'h3,
        TX_SEND = 2'h2
    } hcf_tx_state_t;
endpackage : hcf_pkg

// ---- hdl/hcf_buf.sv ----
// Payload byte memory with registered read data
`timescale 1ns/1ps
module hcf_buf (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [9:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [9:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:1023];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule : hcf_buf

// ---- hdl/hcf_rx_parse.sv ----
// Receive side: header capture, frame checks, parameter stream
`timescale 1ns/1ps
module hcf_rx_parse (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rx_valid,
    input wire hcf_pkg::hcf_byte_t rx_in,
    input wire logic resume,
    output logic rx_ready,
    output hcf_pkg::hcf_byte_t param_out,
    output logic param_valid,
    output logic hdr_valid,
    output logic hdr_bad,
    output hcf_pkg::hcf_hdr_t hdr
);
    logic [10:0] cnt_reg;
    logic [95:0] hv_reg;
    logic [95:0] hv_next;
    logic [15:0] len_w;
    logic take;
    logic at_end;
    logic bad;

    assign take = rx_valid && rx_ready;
    assign len_w = hv_reg[31:16];
    // Limit stop keeps a runaway frame from wrapping the count
    assign at_end = rx_in.last || cnt_reg == hcf_pkg::MSG_MAX - 11'h001
        || (cnt_reg >= 11'h004 && {5'h00, cnt_reg + 11'h001} == len_w);
    assign bad = hv_reg[7:0] != hcf_pkg::MARKER // [RULE_01] [RULE_23]
        || len_w < {5'h00, hcf_pkg::HDR_LEN} // [RULE_04] [RULE_14]
        || len_w > {5'h00, hcf_pkg::MSG_MAX} // [RULE_13]
        || {5'h00, cnt_reg + 11'h001} != len_w;

    always_comb begin
        hv_next = hv_reg;
        if (cnt_reg < hcf_pkg::HDR_LEN) begin
            hv_next[{cnt_reg[3:0], 3'h0} +: 8] = rx_in.data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 11'h000;
            hv_reg <= 96'h0;
        end else if (take) begin
            cnt_reg <= at_end ? 11'h000 : cnt_reg + 11'h001;
            hv_reg <= hv_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hdr_valid <= 1'b0;
            hdr_bad <= 1'b0;
            hdr <= '0;
        end else begin
            hdr_valid <= take && at_end && !bad; // [RULE_15]
            hdr_bad <= take && at_end && bad; // [RULE_23]
            if (take && at_end && !bad) begin
                hdr <= hv_next; // [RULE_19]
            end
        end
    end

    // A good command blocks intake until it has been answered
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_ready <= 1'b1;
        end else if (take && at_end && !bad) begin
            rx_ready <= 1'b0;
        end else if (resume) begin
            rx_ready <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            param_valid <= 1'b0;
            param_out <= '0;
        end else begin
            param_valid <= take && cnt_reg >= hcf_pkg::HDR_LEN;
            param_out <= '{last: at_end, data: rx_in.data};
        end
    end

    property p_bad_marker;
        @(posedge clock) disable iff (!rst_n)
        take && at_end && cnt_reg >= 11'h004 && hv_reg[7:0] != hcf_pkg::MARKER
        |=> hdr_bad && !hdr_valid;
    endproperty
    a_bad_marker: assert property (p_bad_marker) else $error("marker not flagged"); // [RULE_23]

    property p_hdr_only;
        @(posedge clock) disable iff (!rst_n)
        take && at_end && cnt_reg == 11'h00B && !bad |=> hdr_valid ##1 !rx_ready;
    endproperty
    a_hdr_only: assert property (p_hdr_only) else $error("bare header lost"); // [RULE_15]

    property p_len_range;
        @(posedge clock) disable iff (!rst_n)
        hdr_valid |-> hdr.length >= 16'h000C && hdr.length <= 16'h0400;
    endproperty
    a_len_range: assert property (p_len_range) else $error("length out of range"); // [RULE_04]
endmodule : hcf_rx_parse

// ---- testbench/hcf_host_model.sv ----
// Host application model: sends command frames, sinks reply bytes
`timescale 1ns/1ps
module hcf_host_model (
    input wire logic clock,
    output logic rx_valid,
    output hcf_pkg::hcf_byte_t rx_in,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire hcf_pkg::hcf_byte_t tx_out,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic stall = 1'b0;
    logic [1:0] tick = 2'h0;
    int lasts = 0;
    initial begin
        rx_valid = 1'b0;
        rx_in = '0;
        tx_ready = 1'b1;
    end
    // Slow mode keeps ready low three cycles in four to stretch replies
    always @(posedge clock) begin
        tick <= tick + 2'h1;
        tx_ready <= !stall || (tick == 2'h3);
        if (tx_valid && tx_ready) got.push_back(tx_out.data);
        // Frame ends counted so the bench can check the last flag
        if (tx_valid && tx_ready && tx_out.last) lasts++;
    end
    // Byte held until taken; last flag only on the final byte
    task automatic send(input logic [7:0] b[$], output bit hung);
        int n;
        n = 0;
        @(posedge clock);
        foreach (b[i]) begin
            rx_valid <= 1'b1;
            rx_in <= {i == b.size() - 1, b[i]};
            do begin @(posedge clock); n++; end while (!rx_ready && n < 500);
        end
        rx_valid <= 1'b0;
        // Released lines show the inverse, never a stale byte
        rx_in <= {1'b0, ~b[b.size() - 1]};
        hung = (n >= 500);
    endtask : send
endmodule : hcf_host_model

// ---- testbench/tb.sv ----
// Bench: commands from the host model, replies and registers compared
`timescale 1ns/1ps
module tb;
    logic clock, arst_n, cyc, stb, we, ack, rx_valid, rx_ready, param_valid, tx_valid, tx_ready;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, q;
    hcf_pkg::hcf_byte_t rx_in, param_out, tx_out;
    logic [7:0] exp[$], cmd[$], par[$];
    int err_total = 0, total_checks = 0;
    int nfr = 0;
    bit hung;
    hcf_frame_top u_dut (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rx_valid(rx_valid), .rx_in(rx_in), .rx_ready(rx_ready),
        .param_valid(param_valid), .param_out(param_out), .tx_valid(tx_valid),
        .tx_out(tx_out), .tx_ready(tx_ready));
    hcf_host_model u_host (.clock(clock), .rx_valid(rx_valid), .rx_in(rx_in),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_out(tx_out), .tx_ready(tx_ready));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) if (param_valid) par.push_back(param_out.data);
    task automatic final_report(input bit bad);
        if (bad) err_total++;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin @(posedge clock); n++; end while (!ack && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50) final_report(1'b1);
    endtask : wb
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin @(posedge clock); n++; end while (!rx_ready && n < 3000);
        if (!rx_ready) final_report(1'b1);
    endtask : wait_rdy
    // Host node 0, free port 7, type 0, zero reserved byte, parameters follow
    task automatic mk(input logic [7:0] p, input logic [15:0] l, input logic [7:0] c,
                      input logic [7:0] t, input int np);
        cmd = {8'h23, p, l[7:0], l[15:8], 8'h01, 8'h04, 8'h00, 8'h07, 8'h00, t, 8'h00, c};
        for (int i = 0; i < np; i++) cmd.push_back(8'h30 + i[7:0]);
        u_host.send(cmd, hung);
        if (hung) final_report(1'b1);
        repeat (2) @(posedge clock);
    endtask : mk
    // Reply header: addresses swapped against the command above
    task automatic eh(input logic [7:0] p, input logic [7:0] l, input logic [7:0] ty,
                      input logic [7:0] t, input logic [7:0] c);
        exp = {exp, 8'h23, p, l, 8'h00, 8'h00, 8'h07, 8'h01, 8'h04, ty, t, 8'h00, c};
        nfr++;
    endtask : eh
    task automatic cmpq(input int tn);
        chk(u_host.got.size(), exp.size());
        chk(u_host.lasts, nfr);
        foreach (exp[i]) chk(u_host.got[i], exp[i]);
        u_host.got.delete();
        exp.delete();
        nfr = 0;
        u_host.lasts = 0;
        $display("test %0d done", tn);
    endtask : cmpq
    initial begin
        {arst_n, cyc, stb, we, adr, wdat} = '0;
        repeat (16) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        mk(8'h01, 16'h000F, 8'hF0, 8'h5A, 3);
        wb(1'b0, hcf_pkg::REG_STATUS, 0);
        chk(q[2:0], 3'h1);
        chk(rx_ready, 1'b0);
        wb(1'b0, hcf_pkg::REG_HDR0, 0);
        chk(q, 32'h000F0123);
        wb(1'b0, hcf_pkg::REG_HDR2, 0);
        chk(q, 32'hF0005A00);
        chk(par.size(), 3);
        chk({par[0], par[2]}, 16'h3032);
        wb(1'b1, hcf_pkg::REG_RESP_LEN, 32'h2);
        wb(1'b1, hcf_pkg::REG_TX_DATA, 32'hAB);
        wb(1'b1, hcf_pkg::REG_TX_DATA, 32'hCD);
        wb(1'b1, hcf_pkg::REG_FAULT, 32'h0);
        u_host.stall = 1'b1;
        wb(1'b1, hcf_pkg::REG_CTRL, 32'h5);
        wait_rdy();
        eh(8'h01, 8'h0E, 8'h01, 8'h5A, 8'hF0);
        exp = {exp, 8'hAB, 8'hCD};
        eh(8'h01, 8'h11, 8'h02, 8'h5A, 8'hF0);
        exp = {exp, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        cmpq(1);
        u_host.stall = 1'b0;
        mk(8'h02, 16'h000C, 8'h22, 8'h11, 0);
        wb(1'b1, hcf_pkg::REG_RESP_LEN, 32'h0);
        wb(1'b1, hcf_pkg::REG_FAULT, 32'h105);
        wb(1'b1, hcf_pkg::REG_CTRL, 32'h7);
        wait_rdy();
        eh(8'h02, 8'h11, 8'h02, 8'h11, 8'h22);
        exp = {exp, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00};
        cmpq(2);
        mk(8'h00, 16'h000C, 8'h10, 8'h33, 0);
        wb(1'b1, hcf_pkg::REG_CTRL, 32'h1);
        wait_rdy();
        cmpq(3);
        mk(8'h02, 16'h000C, 8'h44, 8'h66, 0);
        wb(1'b1, hcf_pkg::REG_CTRL, 32'h5);
        wait_rdy();
        eh(8'h02, 8'h0C, 8'h01, 8'h66, 8'h44);
        cmpq(4);
        mk(8'h00, 16'h000C, 8'h45, 8'h67, 0);
        wb(1'b1, hcf_pkg::REG_CTRL, 32'h3);
        wait_rdy();
        cmpq(5);
        for (int k = 0; k < 3; k++) begin
            cmd = {8'h23, 8'h00, 8'h0C, 8'h00, 8'h01, 8'h04, 8'h00, 8'h07, 8'h00, 8'h00,
                   8'h00, 8'h00};
            if (k == 0) cmd[0] = 8'h24;
            if (k == 1) begin
                cmd[2] = 8'h0B;
                cmd.delete(11);
            end
            if (k == 2) cmd[3] = 8'h04;
            u_host.send(cmd, hung);
            if (hung) final_report(1'b1);
            repeat (2) @(posedge clock);
            wb(1'b0, hcf_pkg::REG_STATUS, 0);
            chk({q[2], q[0], rx_ready}, 3'b101);
            wb(1'b1, hcf_pkg::REG_STATUS, 32'h4);
            wb(1'b0, hcf_pkg::REG_STATUS, 0);
            chk(q[2], 1'b0);
        end
        $display("test 6 done");
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        wb(1'b0, 8'h20, 0);
        chk(q, 32'h0);
        $display("test 7 done");
        final_report(1'b0);
    end
endmodule : tb
